// File: include/pci_irq_map.vh
/*
 * Constants for the dual-function interrupt routing block: bit positions of the
 * global interrupt status and mask register, reset values, pin codes and power states.
 * Assumes the including file does not define macros with the same names.
 */
`ifndef PCI_IRQ_MAP_VH
`define PCI_IRQ_MAP_VH

`define GIS_UART0_ST 0
`define GIS_UART1_ST 1
`define GIS_MP0_ST 2
`define GIS_MP1_ST 3
`define GIS_UART0_MSK 16
`define GIS_UART1_MSK 17
`define GIS_MP0_MSK 18
`define GIS_MP1_MSK 19
`define GIS_MP0_PD 20
`define GIS_MP1_PD 21
`define GIS_F0_PD_ST 22
`define GIS_F1_PD_ST 23
`define GIS_F0_PD_MSK 24
`define GIS_F1_PD_MSK 25
`define GIS_MP0_FSEL 26
`define GIS_MP1_FSEL 27
`define GIS_PAR_ST 28
`define GIS_PAR_EN 29

`define UIS_UART0_BIT 0
`define UIS_UART1_BIT 6

`define GIS_RESET 32'h2C030000
`define GIS_WR_MASK 32'h2F3F0000
`define GIS_RSVD_HI 2'h0
`define GIS_RSVD_MID 12'h000
`define GIS_RDATA_RESET 32'h00000000
`define PME_RESET 2'h0

`define INTPIN_NONE 8'h00
`define INTPIN_A 8'h01
`define INTPIN_B 8'h02
`define INTPIN_DEFAULT 8'h01

`define PS_D0 2'h0
`define PS_D2 2'h2
`define PS_D3 2'h3

`endif

// File: core/mp_source_route.v
/*
 * One multipurpose pin source: polarity, function routing of its interrupt,
 * powerdown and wake contributions.
 * Assumes pin and control inputs are synchronous to the parent's clock.
 */
`timescale 1ns/1ps
`default_nettype none

module mp_source_route (
	input wire pinLevel,
	input wire invert,
	input wire funcSel,
	input wire intMask,
	input wire pdMask,
	input wire wakeEn,
	output wire state,
	output wire intF0,
	output wire intF1,
	output wire pdOkF0,
	output wire pdReqF1,
	output wire wakeF0,
	output wire wakeF1
);

	////////////////////////////////////////////////////////////////////////////////
	assign state = pinLevel ^ invert;
	assign intF0 = state & intMask & ~funcSel;
	assign intF1 = state & intMask & funcSel;
	// a pin routed to function 0 votes for powerdown while its state is not asserted
	assign pdOkF0 = ~(pdMask & ~funcSel) | ~state;
	// function 1 takes the request at once, no filter
	assign pdReqF1 = pdMask & funcSel & state;
	assign wakeF0 = wakeEn & ~funcSel & state;
	assign wakeF1 = wakeEn & funcSel & state;

endmodule

`default_nettype wire

// File: core/pci_interrupt_routing.v
/*
 * Interrupt aggregation and routing for a dual-function target: global status
 * and mask register, per-source enables, function routing, powerdown sticky
 * bits, wake status and open-drain interrupt and wake lines.
 * Assumes all inputs are synchronous to core_clk, the powerdown filter timer
 * lives outside and answers with f0PdFilterDone, and register strobes are
 * single-cycle pulses from the configuration decoder of either function.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pci_irq_map.vh"

module pci_interrupt_routing (
	input wire core_clk,
	input wire rst,
	input wire regRd,
	input wire regWr,
	input wire [31:0] regWdata,
	output wire [31:0] regRdata,
	input wire eeLoad,
	input wire [1:0] eeUartMask,
	input wire [7:0] eeIntPinF0,
	input wire [7:0] eeIntPinF1,
	output wire [7:0] intPinF0,
	output wire [7:0] intPinF1,
	input wire [7:0] uartIntSrcBits,
	input wire parPortInt,
	input wire [1:0] mpPin,
	input wire [1:0] mpInvert,
	input wire [1:0] mpWakeEn,
	input wire uartsIdle,
	output wire f0PdReady,
	input wire f0PdFilterDone,
	input wire uartWakeF0,
	input wire [1:0] f0PowerState,
	input wire [1:0] f1PowerState,
	input wire [1:0] pmeEn,
	input wire [1:0] pmeStatusClr,
	output wire [1:0] pmeStatus,
	output wire intAOut,
	output wire intAOeN,
	output wire intBOut,
	output wire intBOeN,
	output wire pmeOut,
	output wire pmeOeN,
	output wire uartIerClr
);

	////////////////////////////////////////////////////////////////////////////////
	// state

	reg [31:0] ctrl_q;
	reg [31:0] ctrl_d;
	reg pdF0_q;
	reg pdF0_d;
	reg pdF1_q;
	reg pdF1_d;
	reg [7:0] pinF0_q;
	reg [7:0] pinF1_q;
	reg [31:0] rdata_q;
	reg [1:0] pme_q;
	reg [1:0] pme_d;
	reg intA_q;
	reg intB_q;
	reg pmeAct_q;
	reg ierClr_q;

	wire [31:0] status;
	wire uart0Int;
	wire uart1Int;
	wire [1:0] mpState;
	wire [1:0] mpIntF0;
	wire [1:0] mpIntF1;
	wire [1:0] mpPdOkF0;
	wire [1:0] mpPdReqF1;
	wire [1:0] mpWakeF0;
	wire [1:0] mpWakeF1;
	wire f0Live;
	wire f1Live;
	wire reqF0;
	wire reqF1;
	wire [1:0] wakeSet;
	wire driveA;
	wire driveB;
	wire uart0Req;
	wire uart1Req;
	wire mpReqF0;
	wire mpReqF1;
	wire pdReqF0;
	wire pdReqF1;
	wire parReq;
	wire pdF0Set;
	wire pdF1Set;
	wire f0OnA;
	wire f0OnB;
	wire f1OnA;
	wire f1OnB;
	wire [31:0] ctrlWrite;
	wire [1:0] pmeAsk;

	////////////////////////////////////////////////////////////////////////////////
	// sources

	// uart source bits are active low
	assign uart0Int = ~uartIntSrcBits[`UIS_UART0_BIT];
	assign uart1Int = ~uartIntSrcBits[`UIS_UART1_BIT];

	mp_source_route mpRoute0 (
		.pinLevel(mpPin[0]),
		.invert(mpInvert[0]),
		.funcSel(ctrl_q[`GIS_MP0_FSEL]),
		.intMask(ctrl_q[`GIS_MP0_MSK]),
		.pdMask(ctrl_q[`GIS_MP0_PD]),
		.wakeEn(mpWakeEn[0]),
		.state(mpState[0]),
		.intF0(mpIntF0[0]),
		.intF1(mpIntF1[0]),
		.pdOkF0(mpPdOkF0[0]),
		.pdReqF1(mpPdReqF1[0]),
		.wakeF0(mpWakeF0[0]),
		.wakeF1(mpWakeF1[0])
	);

	mp_source_route mpRoute1 (
		.pinLevel(mpPin[1]),
		.invert(mpInvert[1]),
		.funcSel(ctrl_q[`GIS_MP1_FSEL]),
		.intMask(ctrl_q[`GIS_MP1_MSK]),
		.pdMask(ctrl_q[`GIS_MP1_PD]),
		.wakeEn(mpWakeEn[1]),
		.state(mpState[1]),
		.intF0(mpIntF0[1]),
		.intF1(mpIntF1[1]),
		.pdOkF0(mpPdOkF0[1]),
		.pdReqF1(mpPdReqF1[1]),
		.wakeF0(mpWakeF0[1]),
		.wakeF1(mpWakeF1[1])
	);

	// the filter timer outside sees this; both uarts and every pin on function 0 must agree
	assign f0PdReady = uartsIdle & mpPdOkF0[0] & mpPdOkF0[1];

	////////////////////////////////////////////////////////////////////////////////
	// status view

	assign status = {`GIS_RSVD_HI,
		ctrl_q[`GIS_PAR_EN],
		parPortInt,
		ctrl_q[`GIS_MP1_FSEL:`GIS_F0_PD_MSK],
		pdF1_q,
		pdF0_q,
		ctrl_q[`GIS_MP1_PD:`GIS_UART0_MSK],
		`GIS_RSVD_MID,
		mpState,
		uart1Int,
		uart0Int};

	////////////////////////////////////////////////////////////////////////////////
	// control register

	// read-only and reserved bits keep their flop value, so a write cannot disturb them
	assign ctrlWrite = (ctrl_q & ~`GIS_WR_MASK) | (regWdata & `GIS_WR_MASK);

	always @* begin
		ctrl_d = ctrl_q;
		if (regWr) begin
			ctrl_d = ctrlWrite;
		end
		// eeprom load overrides the uart mask defaults
		if (eeLoad) begin
			ctrl_d[`GIS_UART0_MSK] = eeUartMask[0];
			ctrl_d[`GIS_UART1_MSK] = eeUartMask[1];
		end
	end

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			// uart, pin select and parallel enables come up set, the rest clear
			ctrl_q <= `GIS_RESET;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// interrupt pin fields, writable only by the eeprom loader

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pinF0_q <= `INTPIN_DEFAULT;
			pinF1_q <= `INTPIN_DEFAULT;
		end else if (eeLoad) begin
			pinF0_q <= eeIntPinF0;
			pinF1_q <= eeIntPinF1;
		end
	end

	assign intPinF0 = pinF0_q;
	assign intPinF1 = pinF1_q;

	////////////////////////////////////////////////////////////////////////////////
	// powerdown sticky bits; a set in the read cycle wins so no request is lost

	// a pin on function 1 keeps setting its bit while its state stays asserted
	assign pdF0Set = f0PdFilterDone;
	assign pdF1Set = |mpPdReqF1;

	always @* begin
		pdF0_d = pdF0_q;
		pdF1_d = pdF1_q;
		if (regRd) begin
			pdF0_d = 1'b0;
			pdF1_d = 1'b0;
		end
		if (pdF0Set) begin
			pdF0_d = 1'b1;
		end
		if (pdF1Set) begin
			pdF1_d = 1'b1;
		end
	end

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pdF0_q <= 1'b0;
			pdF1_q <= 1'b0;
		end else begin
			pdF0_q <= pdF0_d;
			pdF1_q <= pdF1_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read data, one cycle after the strobe; both functions share this view

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rdata_q <= `GIS_RDATA_RESET;
		end else if (regRd) begin
			rdata_q <= status;
		end
	end

	assign regRdata = rdata_q;

	////////////////////////////////////////////////////////////////////////////////
	// function requests

	// D2 and D3 silence a function's interrupt whatever the masks hold
	assign f0Live = (f0PowerState != `PS_D2) && (f0PowerState != `PS_D3);
	assign f1Live = (f1PowerState != `PS_D2) && (f1PowerState != `PS_D3);

	// each term is one source behind its own mask; the power state gate comes last
	assign uart0Req = uart0Int & ctrl_q[`GIS_UART0_MSK];
	assign uart1Req = uart1Int & ctrl_q[`GIS_UART1_MSK];
	assign mpReqF0 = |mpIntF0;
	assign pdReqF0 = pdF0_q & ctrl_q[`GIS_F0_PD_MSK];
	assign parReq = parPortInt & ctrl_q[`GIS_PAR_EN];
	assign mpReqF1 = |mpIntF1;
	assign pdReqF1 = pdF1_q & ctrl_q[`GIS_F1_PD_MSK];

	// seven sources: two uarts, two pins, one parallel port and the two powerdown status bits
	assign reqF0 = f0Live & (
		uart0Req |
		uart1Req |
		mpReqF0 |
		pdReqF0);

	assign reqF1 = f1Live & (
		parReq |
		mpReqF1 |
		pdReqF1);

	// reserved pin codes match neither line and so never drive
	assign f0OnA = (pinF0_q == `INTPIN_A);
	assign f0OnB = (pinF0_q == `INTPIN_B);
	assign f1OnA = (pinF1_q == `INTPIN_A);
	assign f1OnB = (pinF1_q == `INTPIN_B);

	assign driveA = (reqF0 & f0OnA) | (reqF1 & f1OnA);
	assign driveB = (reqF0 & f0OnB) | (reqF1 & f1OnB);

	// level outputs: held while any enabled source stays active
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			intA_q <= 1'b0;
			intB_q <= 1'b0;
		end else begin
			intA_q <= driveA;
			intB_q <= driveB;
		end
	end

	// open drain: only ever pull low
	assign intAOut = 1'b0;
	assign intAOeN = ~intA_q;
	assign intBOut = 1'b0;
	assign intBOeN = ~intB_q;

	////////////////////////////////////////////////////////////////////////////////
	// wake status per function, cleared by writing one; set wins

	assign wakeSet[0] = uartWakeF0 | (|mpWakeF0);
	assign wakeSet[1] = |mpWakeF1;

	always @* begin
		pme_d = (pme_q & ~pmeStatusClr) | wakeSet;
	end

	// each function asks on its own; the shared wake pin is their or
	assign pmeAsk = pme_q & pmeEn;

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pme_q <= `PME_RESET;
			pmeAct_q <= 1'b0;
		end else begin
			pme_q <= pme_d;
			pmeAct_q <= |pmeAsk;
		end
	end

	assign pmeStatus = pme_q;
	assign pmeOut = 1'b0;
	assign pmeOeN = ~pmeAct_q;

	////////////////////////////////////////////////////////////////////////////////
	// uart enable clear: held through reset, dropped at the first edge after release

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ierClr_q <= 1'b1;
		end else begin
			ierClr_q <= 1'b0;
		end
	end

	assign uartIerClr = ierClr_q;

endmodule

`default_nettype wire

// File: sim/irq_host_model.sv
/* host side of the shared interrupt lines.
   assumes open-drain drive: enable low pulls the line to the output value */
`timescale 1ns/1ps
`default_nettype none
module irq_host_model (
	input wire logic intAOut,
	input wire logic intAOeN,
	input wire logic intBOut,
	input wire logic intBOeN,
	output logic intALine,
	output logic intBLine
);
////////
// released lines rest at the pull-up level, so a stale value never reads as asserted
assign intALine = intAOeN ? 1'b1 : intAOut;
assign intBLine = intBOeN ? 1'b1 : intBOut;
endmodule
`default_nettype wire

// File: sim/irq_route_chk_asserts.sv
/* port checker of the interrupt routing block.
   assumes it is bound into every routing instance */
`timescale 1ns/1ps
`default_nettype none
module irq_route_chk (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic regRd,
	input wire logic regWr,
	input wire logic eeLoad,
	input wire logic [31:0] regRdata,
	input wire logic [7:0] intPinF0,
	input wire logic [7:0] intPinF1,
	input wire logic [7:0] uartIntSrcBits,
	input wire logic parPortInt,
	input wire logic [1:0] f0PowerState,
	input wire logic [1:0] f1PowerState,
	input wire logic intAOeN,
	input wire logic intBOeN,
	input wire logic intAOut,
	input wire logic intBOut,
	input wire logic pmeOut,
	input wire logic uartWakeF0,
	input wire logic [1:0] pmeEn,
	input wire logic [1:0] pmeStatus,
	input wire logic pmeOeN,
	input wire logic uartIerClr
);
default clocking @(posedge core_clk); endclocking
default disable iff (rst);
////////
sequence sWakeSeen;
	uartWakeF0 ##1 pmeEn[0];
endsequence
sequence sWakeOut;
	pmeStatus[0] ##1 !pmeOeN;
endsequence
AST_UART_STATUS: assert property (
	regRd |=> regRdata[1:0] == ~{$past(uartIntSrcBits[6]), $past(uartIntSrcBits[0])})
	else $error("uart status bits wrong");
AST_PAR_STATUS: assert property (
	regRd |=> regRdata[28] == $past(parPortInt))
	else $error("parallel port status wrong");
AST_NO_LINE_A: assert property (
	intPinF0 != 8'h01 && intPinF1 != 8'h01 |=> intAOeN)
	else $error("line A driven without a function on it");
AST_NO_LINE_B: assert property (
	intPinF0 != 8'h02 && intPinF1 != 8'h02 |=> intBOeN)
	else $error("line B driven without a function on it");
AST_LOW_POWER: assert property (
	f0PowerState[1] && f1PowerState[1] |=> intAOeN && intBOeN)
	else $error("interrupt in low power state");
AST_PIN_FIELD: assert property (
	regWr && !eeLoad |=> $stable(intPinF0) && $stable(intPinF1))
	else $error("pin field changed by a write");
AST_IER_CLR: assert property (
	!$past(rst) |-> !uartIerClr)
	else $error("enable clear held after reset");
AST_WAKE: assert property (
	sWakeSeen |-> sWakeOut)
	else $error("wake not signalled");
AST_DRIVE_LOW: assert property (
	intAOut == 1'b0 && intBOut == 1'b0 && pmeOut == 1'b0)
	else $error("open drain output not low");
endmodule
bind pci_interrupt_routing irq_route_chk u_chk (.*);
`default_nettype wire

// File: sim/testbench.sv
/* random bench with a reference model of the routing block.
   assumes one clock and an asynchronous active-high reset */
`timescale 1ns/1ps
`default_nettype none
module testbench;
logic core_clk = 1'b0;
logic rst = 1'b1;
logic [31:0] seed = 32'h00000017, w = 32'h00000000, r = 32'h00000000;
logic [31:0] regRdata, g, eR;
logic [7:0] intPinF0, intPinF1, p0, p1;
logic [1:0] pmeStatus, s, mp, ps0, ps1, eP;
logic ePmeN, eI;
logic f0PdReady, intAOut, intAOeN, intBOut, intBOeN, pmeOut, pmeOeN, uartIerClr;
logic intALine, intBLine, q0, q1, eA, eB;
int n_errors = 0, n_tests = 0, cyc = 0;
////////
// all inputs but the write data come from one word so every pin moves at once
pci_interrupt_routing u_pci_interrupt_routing (.core_clk(core_clk), .rst(rst),
	.regRd(w[0]), .regWr(w[1]), .regWdata(r), .regRdata(regRdata),
	.eeLoad(w[2] & w[3] & w[4]), .eeUartMask(w[6:5]), .eeIntPinF0({6'h00, w[8:7]}),
	.eeIntPinF1({6'h00, w[10:9]}), .intPinF0(intPinF0), .intPinF1(intPinF1),
	.uartIntSrcBits(w[18:11]), .parPortInt(w[19]), .mpPin(w[21:20]), .mpInvert(w[23:22]),
	.mpWakeEn(w[25:24]), .uartsIdle(w[26]), .f0PdReady(f0PdReady),
	.f0PdFilterDone(w[27] & w[28]), .uartWakeF0(w[29] & w[30]), .f0PowerState(ps0),
	.f1PowerState(ps1), .pmeEn({w[31], w[28]}), .pmeStatusClr(w[30:29] & w[4:3]),
	.pmeStatus(pmeStatus), .intAOut(intAOut), .intAOeN(intAOeN), .intBOut(intBOut),
	.intBOeN(intBOeN), .pmeOut(pmeOut), .pmeOeN(pmeOeN), .uartIerClr(uartIerClr));
irq_host_model u_irq_host_model (.intAOut(intAOut), .intAOeN(intAOeN), .intBOut(intBOut),
	.intBOeN(intBOeN), .intALine(intALine), .intBLine(intBLine));
assign mp = w[21:20] ^ w[23:22];
// low power states kept rare so the lines still get exercised
assign ps0 = {w[12] & w[13], w[12] & w[13] & w[14]};
assign ps1 = {w[15] & w[16], w[15] & w[16] & w[14]};
initial forever #2.5 core_clk = ~core_clk;
////////
function automatic logic [31:0] lfsr(input logic [31:0] v);
	return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
endfunction
task cmpLine(input logic got, input logic exp);
	n_tests++;
	if (got !== exp) begin
		n_errors++;
		$display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
	end
endtask
task cmpWord(input logic [31:0] got, input logic [31:0] exp);
	n_tests++;
	if (got !== exp) begin
		n_errors++;
		$display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
	end
endtask
task end_sim;
	if (n_errors == 0 && n_tests > 0)
		$display("No errors found");
	else
		$display("Errors were found");
	$finish;
endtask
////////
always @(posedge core_clk or posedge rst) begin
	if (rst) begin
		g = 32'h2C030000;
		s = 2'h0;
		p0 = 8'h01;
		p1 = 8'h01;
		eA = 1'b1;
		eB = 1'b1;
		eR = 32'h00000000;
		eP = 2'h0;
		ePmeN = 1'b1;
		eI = 1'b1;
	end else begin
		q0 = !ps0[1] & (g[16] & !w[11] | g[17] & !w[17] | g[24] & s[0]
			| g[18] & mp[0] & !g[26] | g[19] & mp[1] & !g[27]);
		q1 = !ps1[1] & (g[18] & mp[0] & g[26] | g[19] & mp[1] & g[27]
			| g[25] & s[1] | g[29] & w[19]);
		eA = !(p0 == 8'h01 & q0 | p1 == 8'h01 & q1);
		eB = !(p0 == 8'h02 & q0 | p1 == 8'h02 & q1);
		ePmeN = !(|(eP & {w[31], w[28]}));
		eP = eP & ~(w[30:29] & w[4:3]) | {|(w[25:24] & g[27:26] & mp),
			w[29] & w[30] | |(w[25:24] & ~g[27:26] & mp)};
		eI = 1'b0;
		if (w[0])
			eR = {2'h0, g[29], w[19], g[27:24], s, g[21:16], 12'h000, mp, !w[17], !w[11]};
		s = {|(mp & g[21:20] & g[27:26]), w[27] & w[28]} | (s & {2{!w[0]}});
		if (w[1])
			g = g & ~32'h2F3F0000 | r & 32'h2F3F0000;
		if (w[2] & w[3] & w[4]) begin
			g[17:16] = w[6:5];
			p0 = {6'h00, w[8:7]};
			p1 = {6'h00, w[10:9]};
		end
	end
end
always @(negedge core_clk) begin
	if (!rst) begin
		cmpLine(intALine, eA);
		cmpLine(intBLine, eB);
		cmpLine(f0PdReady, w[26] & ~|(mp & g[21:20] & ~g[27:26]));
		cmpWord(regRdata, eR);
		cmpWord({16'h0000, intPinF1, intPinF0}, {16'h0000, p1, p0});
		cmpWord({30'h00000000, pmeStatus}, {30'h00000000, eP});
		cmpLine(pmeOeN, ePmeN);
		cmpLine(uartIerClr, eI);
	end
end
always @(posedge core_clk) begin
	cyc++;
	if (cyc == 4000) begin
		n_errors++;
		end_sim;
	end
end
initial begin
	repeat (2) @(posedge core_clk);
	rst <= 1'b0;
	for (int i = 0; i < 3000; i++) begin
		@(posedge core_clk);
		repeat (9) seed = lfsr(seed);
		w <= seed;
		r <= {seed[15:0], seed[31:16]};
		// a second reset mid-run checks that every default comes back
		if (i == 1500)
			rst <= 1'b1;
		if (i == 1502)
			rst <= 1'b0;
	end
	end_sim;
end
endmodule
`default_nettype wire
